// ==== hw/sdrl_regs.sv ====
// second-loop divider, calibration, readback select and write-protect register bank
// What this block does
// RL1: fast phase-detector flag is 0 at or below 100 MHz, 1 above.
// RL2: during calibration the calibration divider replaces the feedback divider.
// RL3: calibration divider is 18 bits; zero invalid, others divide by value.
// RL4: in internal-oscillator mode every write to register 30 that is not blocked by the lock starts calibration.
// RL5: every calibration run also raises an output synchronization event.
// RL6: 3-bit prescaler: 0 divides by 8, 1 and 2 by 2, else own value.
// RL7: feedback divider is 18 bits; zero invalid, others divide by value.
// RL8: latch polarity bit sets latch-enable level for readback: 0 low, 1 high.
// RL9: 5-bit select picks readback register; 9 and 16 to 23 reserved.
// RL10: reading register 12 returns the select value in bits 20 to 16.
// RL11: host ignores bits 6 to 31 of register 31 readback.
// RL12: while locked, writes to registers 0 to 30 are blocked.
// RL13: only clearing the lock bit in register 31 unlocks.
// RL14: readback works whether or not the lock is set.
// RL15: register 31 stays writable while locked so the lock can clear.
`timescale 1ns/1ps
`include "sdrl_defines.svh"
module sdrl_regs (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic linkClk,
	input wire logic serData,
	input wire logic latchEnablePin,
	input wire logic internalOscMode,
	output logic readbackOut,
	output logic readbackOe_n,
	output logic fastPhaseDetectorFlag,
	output logic [17:0] calibrationFeedbackDivider,
	output logic [17:0] secondLoopFeedbackDivider,
	output logic [2:0] feedbackPrescaler,
	output logic [3:0] prescalerDivideValue,
	output logic [17:0] activeFeedbackDivider,
	output logic activeDividerValid,
	output logic calBusy,
	output logic syncEvent,
	output sdrl_pkg::sdrl_cal_state_t calState,
	output logic writeProtectLock,
	output logic readbackLatchPolarity,
	output logic [4:0] readbackRegisterSelect
);
	import sdrl_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [3:0] prescaleDivide(input logic [2:0] code);
		logic [3:0] value;
		value = {1'b0, code};
		if (code == 3'h0)
			value = `SDRL_PRESCALE_ZERO_DIV;
		else if (code < 3'h3)
			value = `SDRL_PRESCALE_LOW_DIV;
		return value;
	endfunction : prescaleDivide

	function automatic logic reservedSelect(input logic [4:0] sel);
		return (sel == `SDRL_ADDR_RSVD_SINGLE) ||
			((sel >= `SDRL_ADDR_RSVD_LO) && (sel <= `SDRL_ADDR_RSVD_HI));
	endfunction : reservedSelect

	function automatic logic dividerValid(input logic [17:0] div);
		return div != 18'h00000;
	endfunction : dividerValid

	// ----------------------------------------
	// link-domain shifter
	// ----------------------------------------
	logic [31:0] linkWord;
	logic [31:0] rbWord_r;
	logic [31:0] rbWord_nxt;

	sdrl_link_shifter u_shifter (
		.linkClk(linkClk),
		.reset_n(reset_n),
		.serData(serData),
		.readbackWord(rbWord_r),
		.shiftWord(linkWord),
		.readbackBit(readbackOut)
	);

	// ----------------------------------------
	// latch-enable synchroniser
	// ----------------------------------------
	// the link clock stands still while the latch pin is high, so the shifted
	// word is stable when the synchronised rising edge reaches this domain
	logic leMeta_r;
	logic leSync_r;
	logic leDly_r;
	logic leRise;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			leMeta_r <= 1'b0;
			leSync_r <= 1'b0;
			leDly_r <= 1'b0;
		end
		else
		begin
			leMeta_r <= latchEnablePin;
			leSync_r <= leMeta_r;
			leDly_r <= leSync_r;
		end
	end

	assign leRise = leSync_r && !leDly_r;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	logic [4:0] wordAddr;
	logic wrCalCfg;
	logic wrFbDiv;
	logic wrRbLock;
	logic calStart;

	assign wordAddr = linkWord[`SDRL_ADDR_MSB:0];
	assign wrCalCfg = leRise && (wordAddr == `SDRL_ADDR_CAL_CONFIG) && !writeProtectLock; // RL12
	assign wrFbDiv = leRise && (wordAddr == `SDRL_ADDR_FB_DIVIDER) && !writeProtectLock; // RL12
	assign wrRbLock = leRise && (wordAddr == `SDRL_ADDR_RB_LOCK); // RL15
	assign calStart = wrFbDiv && internalOscMode; // RL4

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [31:0] calCfg_r;
	logic [31:0] calCfg_nxt;
	logic [31:0] fbDiv_r;
	logic [31:0] fbDiv_nxt;
	logic [31:0] rbLock_r;
	logic [31:0] rbLock_nxt;

	always_comb
	begin
		calCfg_nxt = calCfg_r;
		fbDiv_nxt = fbDiv_r;
		rbLock_nxt = rbLock_r;
		if (wrCalCfg)
			calCfg_nxt = linkWord & `SDRL_DATA_WRITE_MASK; // RL1 RL3
		if (wrFbDiv)
			fbDiv_nxt = linkWord & `SDRL_DATA_WRITE_MASK; // RL6 RL7
		// the lock bit changes only here and at reset, so no other write can unlock
		if (wrRbLock)
			rbLock_nxt = linkWord & `SDRL_RB_LOCK_WRITE_MASK; // RL13
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			calCfg_r <= `SDRL_CAL_CONFIG_RESET;
			fbDiv_r <= `SDRL_FB_DIVIDER_RESET;
			rbLock_r <= `SDRL_RB_LOCK_RESET;
		end
		else
		begin
			calCfg_r <= calCfg_nxt;
			fbDiv_r <= fbDiv_nxt;
			rbLock_r <= rbLock_nxt;
		end
	end

	assign fastPhaseDetectorFlag = calCfg_r[`SDRL_FAST_PDF_BIT]; // RL1
	assign calibrationFeedbackDivider = calCfg_r[`SDRL_DIV_MSB:`SDRL_DIV_LSB]; // RL3
	assign secondLoopFeedbackDivider = fbDiv_r[`SDRL_DIV_MSB:`SDRL_DIV_LSB]; // RL7
	assign feedbackPrescaler = fbDiv_r[`SDRL_PRESCALE_MSB:`SDRL_PRESCALE_LSB];
	assign writeProtectLock = rbLock_r[`SDRL_LOCK_BIT];
	assign readbackLatchPolarity = rbLock_r[`SDRL_RB_POL_BIT];
	assign readbackRegisterSelect = rbLock_r[`SDRL_RB_SEL_MSB:`SDRL_RB_SEL_LSB];

	// ----------------------------------------
	// frequency calibration
	// ----------------------------------------
	sdrl_cal_state_t calState_r;
	sdrl_cal_state_t calState_nxt;
	logic [15:0] calCount_r;
	logic [15:0] calCount_nxt;
	logic syncEvent_r;
	logic syncEvent_nxt;
	logic [17:0] activeDiv_r;
	logic [17:0] activeDiv_nxt;
	logic activeValid_r;
	logic activeValid_nxt;
	logic [3:0] preDiv_r;
	logic [3:0] preDiv_nxt;

	always_comb
	begin
		calState_nxt = calState_r;
		calCount_nxt = calCount_r;
		case (calState_r)
			SDRL_CAL_IDLE:
			begin
				calCount_nxt = 16'h0000;
			end
			SDRL_CAL_RUN:
			begin
				if (calCount_r == 16'h0000)
					calState_nxt = SDRL_CAL_IDLE;
				else
					calCount_nxt = calCount_r - 16'h0001;
			end
			default:
			begin
				calState_nxt = SDRL_CAL_IDLE;
				calCount_nxt = 16'h0000;
			end
		endcase
		// a new write during a run restarts it with the fresh divider values
		if (calStart)
		begin
			calState_nxt = SDRL_CAL_RUN; // RL4
			calCount_nxt = 16'(`SDRL_CAL_CYCLES - 1);
		end
		syncEvent_nxt = calStart; // RL5
		if (calState_nxt == SDRL_CAL_RUN)
			activeDiv_nxt = calCfg_nxt[`SDRL_DIV_MSB:`SDRL_DIV_LSB]; // RL2
		else
			activeDiv_nxt = fbDiv_nxt[`SDRL_DIV_MSB:`SDRL_DIV_LSB];
		activeValid_nxt = dividerValid(activeDiv_nxt); // RL3 RL7
		preDiv_nxt = prescaleDivide(fbDiv_nxt[`SDRL_PRESCALE_MSB:`SDRL_PRESCALE_LSB]); // RL6
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			calState_r <= SDRL_CAL_IDLE;
			calCount_r <= 16'h0000;
			syncEvent_r <= 1'b0;
			activeDiv_r <= 18'h00000;
			activeValid_r <= 1'b0;
			preDiv_r <= `SDRL_PRESCALE_ZERO_DIV;
		end
		else
		begin
			calState_r <= calState_nxt;
			calCount_r <= calCount_nxt;
			syncEvent_r <= syncEvent_nxt;
			activeDiv_r <= activeDiv_nxt;
			activeValid_r <= activeValid_nxt;
			preDiv_r <= preDiv_nxt;
		end
	end

	assign calState = calState_r;
	assign calBusy = (calState_r == SDRL_CAL_RUN);
	assign syncEvent = syncEvent_r;
	assign activeFeedbackDivider = activeDiv_r;
	assign activeDividerValid = activeValid_r;
	assign prescalerDivideValue = preDiv_r;

	// ----------------------------------------
	// readback
	// ----------------------------------------
	logic rbOe_n_r;
	logic rbOe_n_nxt;
	logic [4:0] selNxt;

	// registers kept elsewhere in the device read as zero from this bank
	always_comb
	begin
		selNxt = rbLock_nxt[`SDRL_RB_SEL_MSB:`SDRL_RB_SEL_LSB];
		rbWord_nxt = 32'h0000_0000;
		if (reservedSelect(selNxt))
			rbWord_nxt = 32'h0000_0000; // RL9
		else if (selNxt == `SDRL_ADDR_SEL_ECHO)
			rbWord_nxt = {11'h000, selNxt, 16'h0000}; // RL10
		else if (selNxt == `SDRL_ADDR_CAL_CONFIG)
			rbWord_nxt = calCfg_nxt;
		else if (selNxt == `SDRL_ADDR_FB_DIVIDER)
			rbWord_nxt = fbDiv_nxt;
		else if (selNxt == `SDRL_ADDR_RB_LOCK)
			rbWord_nxt = rbLock_nxt; // RL11
		// pin is driven whenever the latch level matches, lock or not
		rbOe_n_nxt = !(leSync_r == rbLock_r[`SDRL_RB_POL_BIT]); // RL8 RL14
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			rbWord_r <= 32'h0000_0000;
			rbOe_n_r <= 1'b1;
		end
		else
		begin
			rbWord_r <= rbWord_nxt;
			rbOe_n_r <= rbOe_n_nxt;
		end
	end

	assign readbackOe_n = rbOe_n_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	AST_FAST_FLAG: assert property (wrCalCfg |=> fastPhaseDetectorFlag == $past(linkWord[23])) // RL1
		else $error("fast flag does not follow written bit");
	AST_ACTIVE_DIV: assert property (activeFeedbackDivider ==
		(calBusy ? calibrationFeedbackDivider : secondLoopFeedbackDivider)) // RL2
		else $error("active divider does not follow calibration state");
	AST_DIV_VALID: assert property (activeDividerValid == (activeFeedbackDivider != 18'h00000)) // RL3 RL7
		else $error("divider validity wrong");
	AST_CAL_START: assert property (calStart |=> calBusy [*8]) // RL4
		else $error("calibration did not start and run");
	AST_CAL_END: assert property ($fell(calBusy) |-> $past(calCount_r) == 16'h0000) // RL4
		else $error("calibration ended early");
	AST_SYNC: assert property (calStart |=> syncEvent ##1 !syncEvent || calStart) // RL5
		else $error("sync event missing or too long");
	AST_PRESCALE: assert property (##1 prescalerDivideValue ==
		((feedbackPrescaler == 3'h0) ? 4'h8 :
		(feedbackPrescaler < 3'h3) ? 4'h2 : {1'b0, feedbackPrescaler})) // RL6
		else $error("prescaler divide value wrong");
	AST_RB_RSVD: assert property (reservedSelect(readbackRegisterSelect) |-> rbWord_r == 32'h0) // RL9
		else $error("reserved select returned data");
	AST_RB_ECHO: assert property (readbackRegisterSelect == 5'h0c |->
		rbWord_r[20:16] == 5'h0c) // RL10
		else $error("register 12 readback lacks select value");
	AST_LOCK_BLOCK: assert property (writeProtectLock && leRise && wordAddr != 5'h1f |=>
		$stable(calCfg_r) && $stable(fbDiv_r)) // RL12
		else $error("locked register changed");
	AST_LOCK_CLEAR: assert property ($fell(writeProtectLock) |-> $past(wrRbLock)) // RL13
		else $error("lock cleared without register 31 write");
	AST_R31_WRITE: assert property (wrRbLock |=> writeProtectLock == $past(linkWord[5])) // RL15
		else $error("register 31 write not taken");
	AST_RB_DRIVE: assert property (leSync_r == readbackLatchPolarity && $stable(readbackLatchPolarity)
		|=> !readbackOe_n) // RL8 RL14
		else $error("readback pin not driven at latch level");
endmodule : sdrl_regs

// ==== hw/sdrl_defines.svh ====
// offsets, field positions, reset values and timing counts of the divider/readback/lock bank
`ifndef SDRL_DEFINES_SVH
`define SDRL_DEFINES_SVH

// register numbers carried in the low five bits of each serial frame
`define SDRL_ADDR_CAL_CONFIG 5'h1d
`define SDRL_ADDR_FB_DIVIDER 5'h1e
`define SDRL_ADDR_RB_LOCK 5'h1f
`define SDRL_ADDR_SEL_ECHO 5'h0c
`define SDRL_ADDR_RSVD_SINGLE 5'h09
`define SDRL_ADDR_RSVD_LO 5'h10
`define SDRL_ADDR_RSVD_HI 5'h17
`define SDRL_ADDR_MSB 4

// field positions
`define SDRL_FAST_PDF_BIT 23
`define SDRL_DIV_MSB 22
`define SDRL_DIV_LSB 5
`define SDRL_PRESCALE_MSB 26
`define SDRL_PRESCALE_LSB 24
`define SDRL_RB_POL_BIT 21
`define SDRL_RB_SEL_MSB 20
`define SDRL_RB_SEL_LSB 16
`define SDRL_LOCK_BIT 5

// reset values and write masks
`define SDRL_CAL_CONFIG_RESET 32'h0000_0000
`define SDRL_FB_DIVIDER_RESET 32'h0000_0000
`define SDRL_RB_LOCK_RESET 32'h0000_0000
`define SDRL_DATA_WRITE_MASK 32'hffff_ffe0
`define SDRL_RB_LOCK_WRITE_MASK 32'h003f_0020
`define SDRL_PRESCALE_ZERO_DIV 4'h8
`define SDRL_PRESCALE_LOW_DIV 4'h2

// timing
`define SDRL_CORE_PERIOD_NS 10
`define SDRL_CAL_TIME_NS 10000
`define SDRL_CAL_CYCLES (`SDRL_CAL_TIME_NS / `SDRL_CORE_PERIOD_NS)
`define SDRL_FRAME_BITS 32

`endif

// ==== hw/sdrl_pkg.sv ====
// types shared by the divider/readback/lock bank
package sdrl_pkg;
	typedef enum logic [1:0] {
		SDRL_CAL_IDLE = 2'b00,
		SDRL_CAL_RUN = 2'b01
	} sdrl_cal_state_t;
endpackage : sdrl_pkg

// ==== hw/sdrl_link_shifter.sv ====
// serial-port shifter running on the host's link clock
`timescale 1ns/1ps
`include "sdrl_defines.svh"
module sdrl_link_shifter (
	input wire logic linkClk,
	input wire logic reset_n,
	input wire logic serData,
	input wire logic [31:0] readbackWord,
	output logic [31:0] shiftWord,
	output logic readbackBit
);
	import sdrl_pkg::*;

	// ----------------------------------------
	// reset brought into the link domain
	// ----------------------------------------
	logic rstMeta_r;
	logic rstSync_r;

	always_ff @(posedge linkClk)
	begin
		rstMeta_r <= reset_n;
		rstSync_r <= rstMeta_r;
	end

	// ----------------------------------------
	// shift in, shift out
	// ----------------------------------------
	logic [4:0] bitCount_r;
	logic [4:0] bitCount_nxt;
	logic [31:0] shiftWord_r;
	logic [31:0] shiftWord_nxt;
	logic [31:0] rbShift_r;
	logic [31:0] rbShift_nxt;
	logic readbackBit_r;
	logic readbackBit_nxt;

	// frames are always 32 bits; the counter only marks where readback reloads
	always_comb
	begin
		bitCount_nxt = bitCount_r + 5'h01;
		shiftWord_nxt = {shiftWord_r[30:0], serData};
		if (bitCount_r == 5'h00)
		begin
			// readback word is quasi-static: core only changes it between frames
			readbackBit_nxt = readbackWord[31];
			rbShift_nxt = {readbackWord[30:0], 1'b0};
		end
		else
		begin
			readbackBit_nxt = rbShift_r[31];
			rbShift_nxt = {rbShift_r[30:0], 1'b0};
		end
	end

	always_ff @(posedge linkClk)
	begin
		if (!rstSync_r)
		begin
			bitCount_r <= 5'h00;
			shiftWord_r <= 32'h0000_0000;
			rbShift_r <= 32'h0000_0000;
			readbackBit_r <= 1'b0;
		end
		else
		begin
			bitCount_r <= bitCount_nxt;
			shiftWord_r <= shiftWord_nxt;
			rbShift_r <= rbShift_nxt;
			readbackBit_r <= readbackBit_nxt;
		end
	end

	assign shiftWord = shiftWord_r;
	assign readbackBit = readbackBit_r;
endmodule : sdrl_link_shifter

// ==== testbench/sdrl_host_model.sv ====
// host model driving the three-wire serial configuration port
`timescale 1ns/1ps
module sdrl_host_model (
	output logic linkClk,
	output logic serData,
	output logic latchEnablePin,
	input wire logic readbackOut
);
	localparam realtime HALF = 62.5;

	initial
	begin
		linkClk = 1'b0;
		serData = 1'b0;
		latchEnablePin = 1'b0;
	end

	task automatic pulses(input int cnt);
		repeat (cnt)
		begin
			#HALF linkClk = 1'b1;
			#HALF linkClk = 1'b0;
		end
	endtask : pulses

	// data moves on the falling link edge so it is stable at the rising one
	task automatic shift(input logic [31:0] txWord, output logic [31:0] rxWord);
		for (int k = 31; k >= 0; k--)
		begin
			serData = txWord[k];
			#HALF linkClk = 1'b1;
			#HALF linkClk = 1'b0;
			rxWord[k] = readbackOut;
		end
		// released line: show the inverse so a stale bit is never trusted
		serData = ~txWord[0];
	endtask : shift

	// clock stays parked low while the latch pin is high
	task automatic writeFrame(input logic [31:0] frame);
		logic [31:0] unused;
		shift(frame, unused);
		#HALF latchEnablePin = 1'b1;
		#100 latchEnablePin = 1'b0;
		#HALF;
	endtask : writeFrame

	// latch pin held low for the whole readback frame
	task automatic readFrame(output logic [31:0] rxWord);
		shift(32'h0000_0000, rxWord);
	endtask : readFrame

	task automatic setLe(input logic level);
		latchEnablePin = level;
	endtask : setLe
endmodule : sdrl_host_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the divider, calibration, readback and lock bank
`timescale 1ns/1ps
`include "sdrl_defines.svh"
module tb_top;
	import sdrl_pkg::*;
	logic core_clk, reset_n, internalOscMode, linkClk, serData, latchEnablePin;
	logic readbackOut, readbackOe_n, fastPhaseDetectorFlag, activeDividerValid;
	logic calBusy, syncEvent, writeProtectLock, readbackLatchPolarity;
	logic [17:0] calibrationFeedbackDivider, secondLoopFeedbackDivider, activeFeedbackDivider;
	logic [17:0] div;
	logic [2:0] feedbackPrescaler;
	logic [3:0] prescalerDivideValue;
	logic [4:0] readbackRegisterSelect;
	sdrl_cal_state_t calState;
	logic [31:0] m29, m30, m31, rx;
	integer seed;
	int num_errors, comparisons, n;
	logic [4:0] sels [7] = '{5'h1d, 5'h1e, 5'h0c, 5'h09, 5'h14, 5'h03, 5'h1f};

	sdrl_regs dut_u (.core_clk(core_clk), .reset_n(reset_n), .linkClk(linkClk),
		.serData(serData), .latchEnablePin(latchEnablePin), .internalOscMode(internalOscMode),
		.readbackOut(readbackOut), .readbackOe_n(readbackOe_n),
		.fastPhaseDetectorFlag(fastPhaseDetectorFlag),
		.calibrationFeedbackDivider(calibrationFeedbackDivider),
		.secondLoopFeedbackDivider(secondLoopFeedbackDivider),
		.feedbackPrescaler(feedbackPrescaler), .prescalerDivideValue(prescalerDivideValue),
		.activeFeedbackDivider(activeFeedbackDivider), .activeDividerValid(activeDividerValid),
		.calBusy(calBusy), .syncEvent(syncEvent), .calState(calState),
		.writeProtectLock(writeProtectLock), .readbackLatchPolarity(readbackLatchPolarity),
		.readbackRegisterSelect(readbackRegisterSelect));
	sdrl_host_model host_u (.linkClk(linkClk), .serData(serData),
		.latchEnablePin(latchEnablePin), .readbackOut(readbackOut));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ---------------------------------------------------------------
	// checking and reporting
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expVal);
		comparisons++;
		if (seen !== expVal)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, expVal, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// ---------------------------------------------------------------
	// register model and bus tasks
	// ---------------------------------------------------------------
	task automatic wr(input logic [31:0] f);
		if (f[4:0] == `SDRL_ADDR_RB_LOCK)
			m31 = f & `SDRL_RB_LOCK_WRITE_MASK;
		else if (!m31[`SDRL_LOCK_BIT] && f[4:0] == `SDRL_ADDR_CAL_CONFIG)
			m29 = f & `SDRL_DATA_WRITE_MASK;
		else if (!m31[`SDRL_LOCK_BIT] && f[4:0] == `SDRL_ADDR_FB_DIVIDER)
			m30 = f & `SDRL_DATA_WRITE_MASK;
		host_u.writeFrame(f);
		@(negedge core_clk);
		check("fastFlag", fastPhaseDetectorFlag, m29[23]);
		check("calDiv", calibrationFeedbackDivider, m29[22:5]);
		check("fbDiv", secondLoopFeedbackDivider, m30[22:5]);
		check("prescaler", feedbackPrescaler, m30[26:24]);
		check("lock", writeProtectLock, m31[5]);
		check("polarity", readbackLatchPolarity, m31[21]);
		check("select", readbackRegisterSelect, m31[20:16]);
	endtask : wr

	task automatic rdAll();
		for (int i = 0; i < 7; i++)
		begin
			wr({11'h000, sels[i], 16'h0000} | (m31 & 32'h0020_0020) | 32'h1f);
			check("oeLow", readbackOe_n, 1'b0);
			host_u.readFrame(rx);
			// only the lock bit of a register 31 word carries meaning
			if (sels[i] == 5'h1f)
				check("rbLock", rx[5], m31[5]);
			else
				check("rbWord", rx, sels[i] == 5'h1d ? m29 : sels[i] == 5'h1e ? m30 :
					sels[i] == 5'h0c ? {11'h000, sels[i], 16'h0000} : 32'h0);
		end
		$display("test readback done");
	endtask : rdAll

	task automatic calRun(input logic [31:0] f);
		fork
			wr(f);
			begin
				n = 0;
				while (syncEvent !== 1'b1 && n < 600)
				begin
					@(negedge core_clk);
					n++;
				end
				if (n >= 600)
				begin
					num_errors++;
					final_report();
				end
				else
				begin
					check("calBusy", calBusy, 1'b1);
					check("calState", calState, SDRL_CAL_RUN);
					check("activeDiv", activeFeedbackDivider, m29[22:5]);
					@(negedge core_clk);
					check("syncPulse", syncEvent, 1'b0);
					n = 0;
					while (calBusy === 1'b1 && n < 1100)
					begin
						@(negedge core_clk);
						n++;
					end
					if (n >= 1100)
					begin
						num_errors++;
						final_report();
					end
					else
					begin
						// busy spans the whole count; the first busy sample is taken before n starts
						check("calTime", n, `SDRL_CAL_CYCLES - 1);
						check("activeDiv", activeFeedbackDivider, m30[22:5]);
					end
				end
			end
		join
		$display("test calibration done");
	endtask : calRun

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		seed = 32'hf2d6313e;
		reset_n = 1'b0;
		internalOscMode = 1'b0;
		m29 = 32'h0;
		m30 = 32'h0;
		m31 = 32'h0;
		num_errors = 0;
		comparisons = 0;
		// link clock must run during reset so its domain clears too
		host_u.pulses(4);
		@(negedge core_clk);
		reset_n = 1'b1;
		host_u.pulses(2);
		repeat (3) @(negedge core_clk);
		check("rstA", {fastPhaseDetectorFlag, calibrationFeedbackDivider, feedbackPrescaler}, 0);
		check("rstB", {secondLoopFeedbackDivider, writeProtectLock, readbackLatchPolarity}, 0);
		check("rstC", {readbackRegisterSelect, calBusy, syncEvent, calState}, 0);
		check("rstValid", {activeFeedbackDivider, activeDividerValid}, 0);
		check("rstDiv", prescalerDivideValue, `SDRL_PRESCALE_ZERO_DIV);
		$display("test reset done");
		for (int c = 0; c < 8; c++)
		begin
			div = 18'(1 + $unsigned($random(seed)) % 262143);
			wr({5'h00, 3'(c), 1'b0, div, `SDRL_ADDR_FB_DIVIDER});
			check("presDiv", prescalerDivideValue, c == 0 ? 8 : c < 3 ? 2 : c);
			check("activeDiv", activeFeedbackDivider, div);
			check("activeValid", activeDividerValid, 1'b1);
			check("calIdle", calBusy, 1'b0);
		end
		$display("test prescaler done");
		for (int f = 0; f < 2; f++)
		begin
			div = 18'(1 + $unsigned($random(seed)) % 262143);
			wr({8'($random(seed)), 1'(f), div, `SDRL_ADDR_CAL_CONFIG});
		end
		@(negedge core_clk);
		internalOscMode = 1'b1;
		calRun({8'($random(seed)), 1'b0, 18'h3ffff, `SDRL_ADDR_FB_DIVIDER});
		rdAll();
		wr(32'h0000_003f);
		wr({8'h5a, 1'b0, 18'h00123, `SDRL_ADDR_CAL_CONFIG});
		wr({8'h03, 1'b0, 18'h00001, `SDRL_ADDR_FB_DIVIDER});
		check("lockedNoCal", calBusy, 1'b0);
		rdAll();
		wr(32'h0000_001f);
		wr({8'ha5, 1'b1, 18'h00001, `SDRL_ADDR_CAL_CONFIG});
		$display("test lock done");
		wr(32'h0020_001f);
		host_u.setLe(1'b1);
		repeat (5) @(negedge core_clk);
		check("oeHigh", readbackOe_n, 1'b0);
		host_u.setLe(1'b0);
		repeat (5) @(negedge core_clk);
		check("oeOff", readbackOe_n, 1'b1);
		$display("test polarity done");
		final_report();
	end
endmodule : tb_top
